// ---- core/phyan_defines.svh ----
`ifndef PHYAN_DEFINES_SVH
`define PHYAN_DEFINES_SVH

// register offsets on the management interface
`define PHYAN_OFF_IDENT_HIGH   5'h02
`define PHYAN_OFF_IDENT_LOW    5'h03
`define PHYAN_OFF_ADVERTISE    5'h04
`define PHYAN_OFF_PARTNER      5'h05

// advertisement field positions
`define PHYAN_ADV_NEXT_PAGE_BIT    15
`define PHYAN_ADV_RSV14_BIT        14
`define PHYAN_ADV_REMOTE_FAULT_BIT 13
`define PHYAN_ADV_PAUSE_BIT        10
`define PHYAN_ADV_FOUR_PAIR_BIT    9
`define PHYAN_ADV_FAST_FULL_BIT    8
`define PHYAN_ADV_FAST_HALF_BIT    7
`define PHYAN_ADV_SLOW_FULL_BIT    6
`define PHYAN_ADV_SLOW_HALF_BIT    5

// advertisement reset value before straps are applied, and writable mask
`define PHYAN_ADV_RESET        16'h0001
`define PHYAN_ADV_WR_MASK      16'hA5FF
`define PHYAN_SELECTOR_8023    5'h01

// management frame figures
`define PHYAN_PREAMBLE_BITS    6'h20
`define PHYAN_ADDR_BITS        5'h0A
`define PHYAN_DATA_BITS        5'h10
`define PHYAN_OP_READ          2'h2
`define PHYAN_OP_WRITE         2'h1

`endif

// ---- core/phyan_pkg.sv ----
package phyan_pkg;

  // management frame receiver states
  typedef enum logic [2:0]
  {
    PHYAN_PRE,
    PHYAN_START,
    PHYAN_OPCODE,
    PHYAN_ADDR,
    PHYAN_TURN,
    PHYAN_DATA
  } phyan_frame_e;

  typedef logic [15:0] phyan_word_t;

endpackage : phyan_pkg

// ---- core/phyan_partner_page.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "phyan_defines.svh"

module phyan_partner_page
  import phyan_pkg::*;
(
  // clock and synchronised reset
  input  wire logic        clock,
  input  wire logic        rst_sync_b,
  // pages received by the negotiation engine
  input  wire logic        base_valid,
  input  wire phyan_word_t base_page,
  input  wire logic        next_valid,
  input  wire phyan_word_t next_page,
  input  wire logic        an_done,
  input  wire logic        next_page_on,
  // stored partner word
  output phyan_word_t      partner_word
);

  phyan_word_t partner_reg;   // last accepted partner page
  phyan_word_t partner_next;  // its next value
  logic        take_next;     // next page may replace the base page

  // next pages only overwrite once negotiation has finished
  assign take_next    = next_valid && an_done && next_page_on;
  assign partner_next = take_next  ? next_page :
                        base_valid ? base_page : partner_reg;
  assign partner_word = partner_reg;

  // holding register, cleared by reset
  always_ff @(posedge clock or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
      partner_reg <= 16'h0000;
    else
      partner_reg <= partner_next;
  end

  base_load_a: assert property (@(posedge clock) disable iff (!rst_sync_b)
    (base_valid && !take_next) |=> (partner_word == $past(base_page)))
    else $error("partner base page not stored");

  next_gate_a: assert property (@(posedge clock) disable iff (!rst_sync_b)
    (!base_valid && !(next_valid && an_done && next_page_on)) |=> $stable(partner_word))
    else $error("partner page changed without a load");

  next_take_a: assert property (@(posedge clock) disable iff (!rst_sync_b)
    take_next |=> (partner_word == $past(next_page)))
    else $error("partner next page not stored");

endmodule : phyan_partner_page
`default_nettype wire

// ---- core/phyan_regs.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "phyan_defines.svh"

module phyan_regs
  import phyan_pkg::*;
#(
  parameter logic [23:0] ORG_CODE       = 24'h5A3C21, // arbitrary value
  parameter logic [5:0]  MODEL_NUMBER   = 6'h2A,      // arbitrary value
  parameter logic [3:0]  MODEL_REVISION = 4'h1        // arbitrary value
)
(
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst_b,
  // serial management pins
  input  wire logic        mdc,
  input  wire logic        mdio_in,
  output logic             mdio_out,
  output logic             mdio_oe,
  input  wire logic [4:0]  phy_addr,
  // strap pins
  input  wire logic        strap_pause,
  input  wire logic        strap_fast_full,
  input  wire logic        strap_fast_half,
  input  wire logic        strap_slow_full,
  input  wire logic        strap_slow_half,
  // negotiation engine side
  input  wire logic        partner_base_valid,
  input  wire phyan_word_t partner_base_page,
  input  wire logic        partner_next_valid,
  input  wire phyan_word_t partner_next_page,
  input  wire logic        an_complete,
  output phyan_word_t      advertise_page
);

  // reset release chain
  logic        rst_meta_reg;       // first release stage
  logic        rst_sync_b;         // released reset used everywhere else

  // frame receiver state
  phyan_frame_e state_reg;         // where in the frame we are
  phyan_frame_e state_next;
  logic [5:0]  pre_cnt_reg;        // consecutive preamble ones
  logic [5:0]  pre_cnt_next;
  logic [4:0]  bit_cnt_reg;        // bits taken in the current field
  logic [4:0]  bit_cnt_next;
  logic [1:0]  op_reg;             // opcode of the frame
  logic [1:0]  op_next;
  logic [9:0]  addr_reg;           // phy and register address
  logic [9:0]  addr_next;
  phyan_word_t shift_reg;          // data in or out
  phyan_word_t shift_next;
  logic        drive_reg;          // we own the data pin
  logic        drive_next;
  logic        out_reg;            // level we drive
  logic        out_next;
  logic        mdc_prev_reg;       // last clock level seen

  // register state
  phyan_word_t adv_reg;            // advertisement register
  phyan_word_t adv_next;
  logic        strap_load_reg;     // straps not yet taken
  phyan_word_t partner_word;       // stored partner ability
  phyan_word_t ident_high;         // first identifier word
  phyan_word_t ident_low;          // second identifier word
  phyan_word_t read_word;          // word selected by address
  phyan_word_t strap_word;         // straps placed in their bit positions
  phyan_word_t write_word;         // write data after masking
  // decoded events
  logic        mdc_rise;           // one-cycle pulse per management clock
  logic        addr_match;         // frame is for this phy
  logic        last_addr_bit;
  logic        last_data_bit;
  logic        write_commit;       // write frame to the advertisement register ended for us
  logic [4:0]  reg_addr;
  // write mask helper; read-only and reserved bits fall away
  function automatic phyan_word_t phyan_mask_adv(input phyan_word_t w);
    phyan_mask_adv = w & `PHYAN_ADV_WR_MASK;
  endfunction : phyan_mask_adv

  // release reset through two stages; assertion stays asynchronous
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rst_meta_reg <= 1'b0;
      rst_sync_b   <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_sync_b   <= rst_meta_reg;
    end
  end

  // identifier words: org code held as ieee bits 1..24 in [23:0]
  assign ident_high = ORG_CODE[21:6];
  assign ident_low  = {ORG_CODE[5:0], MODEL_NUMBER, MODEL_REVISION};
  // read select; unmapped offsets answer zero
  assign reg_addr  = addr_reg[4:0];
  assign read_word = (reg_addr == `PHYAN_OFF_IDENT_HIGH) ? ident_high :
                     (reg_addr == `PHYAN_OFF_IDENT_LOW)  ? ident_low  :
                     (reg_addr == `PHYAN_OFF_ADVERTISE)  ? adv_reg    :
                     (reg_addr == `PHYAN_OFF_PARTNER)    ? partner_word :
                     16'h0000;
  // strap levels placed on their advertisement bits
  assign strap_word = {5'h00, strap_pause, 1'b0, strap_fast_full, strap_fast_half,
                       strap_slow_full, strap_slow_half, 5'h00};
  assign write_word = phyan_mask_adv({shift_reg[14:0], mdio_in}); // last bit still on pin
  // frame decode
  assign mdc_rise      = mdc && !mdc_prev_reg;
  assign addr_match    = (addr_reg[9:5] == phy_addr);
  assign last_addr_bit = (bit_cnt_reg == `PHYAN_ADDR_BITS - 5'h01);
  assign last_data_bit = (bit_cnt_reg == `PHYAN_DATA_BITS - 5'h01);
  assign write_commit  = mdc_rise && (state_reg == PHYAN_DATA) && last_data_bit &&
                         (op_reg == `PHYAN_OP_WRITE) && addr_match &&
                         (reg_addr == `PHYAN_OFF_ADVERTISE);
  // strap defaults land once, in the first cycle after release
  assign adv_next = strap_load_reg ? (`PHYAN_ADV_RESET | strap_word) :
                    write_commit   ? write_word :
                    adv_reg;
  // advertisement register; only writable fields ever change
  always_ff @(posedge clock or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      adv_reg        <= `PHYAN_ADV_RESET;
      strap_load_reg <= 1'b1;
    end
    else
    begin
      adv_reg        <= adv_next;
      strap_load_reg <= 1'b0;
    end
  end

  // the negotiation engine always sees the live register
  assign advertise_page = adv_reg;

  // frame receiver, advanced on each management clock rise
  always_comb
  begin
    state_next   = state_reg;
    pre_cnt_next = pre_cnt_reg;
    bit_cnt_next = bit_cnt_reg;
    op_next      = op_reg;
    addr_next    = addr_reg;
    shift_next   = shift_reg;
    drive_next   = drive_reg;
    out_next     = out_reg;
    if (mdc_rise)
    begin
      case (state_reg)
        PHYAN_PRE:
        begin
          // a zero after a full preamble is the first start bit
          if (mdio_in)
            pre_cnt_next = (pre_cnt_reg == `PHYAN_PREAMBLE_BITS) ? pre_cnt_reg
                                                                 : pre_cnt_reg + 6'h01;
          else if (pre_cnt_reg == `PHYAN_PREAMBLE_BITS)
            state_next = PHYAN_START;
          else
            pre_cnt_next = 6'h00;
        end
        PHYAN_START:
        begin
          bit_cnt_next = 5'h00;
          pre_cnt_next = 6'h00;
          state_next   = mdio_in ? PHYAN_OPCODE : PHYAN_PRE;
        end
        PHYAN_OPCODE:
        begin
          op_next      = {op_reg[0], mdio_in};
          bit_cnt_next = bit_cnt_reg + 5'h01;
          if (bit_cnt_reg == 5'h01)
          begin
            bit_cnt_next = 5'h00;
            state_next   = PHYAN_ADDR;
          end
        end
        PHYAN_ADDR:
        begin
          addr_next    = {addr_reg[8:0], mdio_in};
          bit_cnt_next = bit_cnt_reg + 5'h01;
          if (last_addr_bit)
          begin
            bit_cnt_next = 5'h00;
            state_next   = PHYAN_TURN;
          end
        end
        PHYAN_TURN:
        begin
          bit_cnt_next = bit_cnt_reg + 5'h01;
          if (bit_cnt_reg == 5'h00)
          begin
            // drive the second turnaround bit low on our reads
            if ((op_reg == `PHYAN_OP_READ) && addr_match)
            begin
              drive_next = 1'b1;
              out_next   = 1'b0;
              shift_next = read_word;
            end
          end
          else
          begin
            bit_cnt_next = 5'h00;
            state_next   = PHYAN_DATA;
            out_next     = shift_reg[15];
            if (drive_reg)
              shift_next = {shift_reg[14:0], 1'b0};
          end
        end
        PHYAN_DATA:
        begin
          bit_cnt_next = bit_cnt_reg + 5'h01;
          if (drive_reg)
          begin
            out_next   = shift_reg[15];
            shift_next = {shift_reg[14:0], 1'b0};
          end
          else
            shift_next = {shift_reg[14:0], mdio_in};
          if (last_data_bit)
          begin
            // release the pin; the next frame needs a fresh preamble
            drive_next   = 1'b0;
            out_next     = 1'b0;
            bit_cnt_next = 5'h00;
            pre_cnt_next = 6'h00;
            state_next   = PHYAN_PRE;
          end
        end
        default:
          state_next = PHYAN_PRE;
      endcase
    end
  end

  // frame receiver flops
  always_ff @(posedge clock or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      state_reg    <= PHYAN_PRE;
      pre_cnt_reg  <= 6'h00;
      bit_cnt_reg  <= 5'h00;
      op_reg       <= 2'h0;
      addr_reg     <= 10'h000;
      shift_reg    <= 16'h0000;
      drive_reg    <= 1'b0;
      out_reg      <= 1'b0;
      mdc_prev_reg <= 1'b0;
    end
    else
    begin
      state_reg    <= state_next;
      pre_cnt_reg  <= pre_cnt_next;
      bit_cnt_reg  <= bit_cnt_next;
      op_reg       <= op_next;
      addr_reg     <= addr_next;
      shift_reg    <= shift_next;
      drive_reg    <= drive_next;
      out_reg      <= out_next;
      mdc_prev_reg <= mdc;
    end
  end
  assign mdio_out = out_reg;
  assign mdio_oe  = drive_reg;

  // partner ability storage
  phyan_partner_page u_partner
  (
    .clock        (clock),
    .rst_sync_b   (rst_sync_b),
    .base_valid   (partner_base_valid),
    .base_page    (partner_base_page),
    .next_valid   (partner_next_valid),
    .next_page    (partner_next_page),
    .an_done      (an_complete),
    .next_page_on (adv_reg[`PHYAN_ADV_NEXT_PAGE_BIT]),
    .partner_word (partner_word)
  );

  reserved_zero_a: assert property (@(posedge clock) disable iff (!rst_sync_b)
    !adv_reg[14] && !adv_reg[12] && !adv_reg[11])
    else $error("reserved advertisement bit set");
  four_pair_a: assert property (@(posedge clock) disable iff (!rst_sync_b)
    !advertise_page[9])
    else $error("four pair ability advertised");
  strap_load_a: assert property (@(posedge clock) disable iff (!rst_sync_b)
    strap_load_reg |=> (adv_reg[10] == $past(strap_pause)) &&
                       (adv_reg[8:5] == $past({strap_fast_full, strap_fast_half,
                                               strap_slow_full, strap_slow_half})))
    else $error("strap defaults not loaded");
  strap_sel_a: assert property (@(posedge clock) disable iff (!rst_sync_b)
    strap_load_reg |=> (adv_reg[4:0] == `PHYAN_SELECTOR_8023) && !adv_reg[15] && !adv_reg[13])
    else $error("advertisement defaults wrong");
  write_take_a: assert property (@(posedge clock) disable iff (!rst_sync_b)
    (write_commit && !strap_load_reg) |=>
      (adv_reg == ($past({shift_reg[14:0], mdio_in}) & `PHYAN_ADV_WR_MASK)))
    else $error("advertisement write lost");
  adv_hold_a: assert property (@(posedge clock) disable iff (!rst_sync_b)
    (!write_commit && !strap_load_reg) |=> $stable(adv_reg))
    else $error("advertisement changed without a write");
  ident_read_a: assert property (@(posedge clock) disable iff (!rst_sync_b)
    (mdc_rise && state_reg == PHYAN_TURN && bit_cnt_reg == 5'h00 && op_reg == 2'h2 &&
     addr_match && reg_addr == 5'h02) |=> (shift_reg == ORG_CODE[21:6]) && mdio_oe && !mdio_out)
    else $error("first identifier read wrong");
  ident_low_a: assert property (@(posedge clock) disable iff (!rst_sync_b)
    (mdc_rise && state_reg == PHYAN_TURN && bit_cnt_reg == 5'h00 && op_reg == 2'h2 &&
     addr_match && reg_addr == 5'h03) |=>
      (shift_reg == {ORG_CODE[5:0], MODEL_NUMBER, MODEL_REVISION}))
    else $error("second identifier read wrong");
  adv_out_a: assert property (@(posedge clock) disable iff (!rst_sync_b)
    (mdc_rise && state_reg == PHYAN_TURN && bit_cnt_reg == 5'h00 && op_reg == 2'h2 &&
     addr_match && reg_addr == 5'h04) |=> (shift_reg == $past(advertise_page)))
    else $error("advertised page differs from register");

endmodule : phyan_regs
`default_nettype wire

// ---- tb/phyan_mgmt_master.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "phyan_defines.svh"

module phyan_mgmt_master
  import phyan_pkg::*;
(
  // shared clock
  input  wire logic clock,
  // management wire
  input  wire logic mdio_wire,
  output logic      mdc,
  output logic      mdio_drv,
  output logic      mdio_drv_en
);
  // idle: clock parked low, line released to the pull-up
  initial
  begin
    mdc = 1'b0;
    mdio_drv = 1'b0;
    mdio_drv_en = 1'b0;
  end

  // one mdc period at clock/4; sample just before the rise, when the bit has settled
  task mbit(input logic drive, input logic b, output logic s);
    @(negedge clock);
    mdc = 1'b0;
    mdio_drv_en = drive;
    mdio_drv = b;
    @(negedge clock);
    @(negedge clock);
    s = mdio_wire;
    mdc = 1'b1;
    @(negedge clock);
  endtask : mbit

  // whole frame with fresh preamble; reads release the line from turnaround on
  task frame(input logic [1:0] op, input logic [4:0] reg_addr, input logic [4:0] phy,
             input phyan_word_t wdata, output phyan_word_t rdata);
    logic [45:0] head;
    phyan_word_t wd;
    logic        wr;
    logic        s;
    integer      i;
    wd = wdata & 16'hE7FF;
    wr = (op == `PHYAN_OP_WRITE);
    head = {32'hFFFFFFFF, 2'b01, op, phy, reg_addr};
    for (i = 45; i >= 0; i--)
      mbit(1'b1, head[i], s);
    mbit(wr, 1'b1, s);
    mbit(wr, 1'b0, s);
    for (i = 15; i >= 0; i--)
    begin
      mbit(wr, wd[i], s);
      rdata[i] = s;
    end
    // park low and give the line back
    @(negedge clock);
    mdc = 1'b0;
    mdio_drv_en = 1'b0;
    @(negedge clock);
  endtask : frame
endmodule : phyan_mgmt_master
`default_nettype wire

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "phyan_defines.svh"

module testbench
  import phyan_pkg::*;
;
  localparam logic [23:0] ORG   = 24'h3C96E5; // arbitrary value
  localparam logic [5:0]  MODEL = 6'h15;      // arbitrary value
  localparam logic [3:0]  REV   = 4'h6;       // arbitrary value
  localparam logic [4:0]  PHY   = 5'h13;      // address of this device

  logic        clock;
  logic        rst_b;
  logic        mdc;
  logic        mdio_drv;
  logic        mdio_drv_en;
  logic        mdio_out;
  logic        mdio_oe;
  wire         mdio_wire;
  logic [4:0]  phy_addr;
  logic [4:0]  straps;          // pause, fast full, fast half, slow full, slow half
  logic        base_valid;
  phyan_word_t base_page;
  logic        next_valid;
  phyan_word_t next_page;
  logic        an_complete;
  phyan_word_t advertise_page;
  phyan_word_t rdata;
  integer      err_count;
  integer      compares;
  integer      cycles;

  // line has a pull-up, so nobody driving reads as one
  assign mdio_wire = mdio_oe ? mdio_out : (mdio_drv_en ? mdio_drv : 1'b1);

  phyan_regs #(.ORG_CODE(ORG), .MODEL_NUMBER(MODEL), .MODEL_REVISION(REV)) dut (
    .clock(clock), .rst_b(rst_b), .mdc(mdc), .mdio_in(mdio_wire),
    .mdio_out(mdio_out), .mdio_oe(mdio_oe), .phy_addr(phy_addr),
    .strap_pause(straps[4]), .strap_fast_full(straps[3]), .strap_fast_half(straps[2]),
    .strap_slow_full(straps[1]), .strap_slow_half(straps[0]),
    .partner_base_valid(base_valid), .partner_base_page(base_page),
    .partner_next_valid(next_valid), .partner_next_page(next_page),
    .an_complete(an_complete), .advertise_page(advertise_page));

  phyan_mgmt_master mgmt (
    .clock(clock), .mdio_wire(mdio_wire), .mdc(mdc),
    .mdio_drv(mdio_drv), .mdio_drv_en(mdio_drv_en));

  // 10 MHz clock
  initial
  begin
    clock = 1'b0;
    forever
      #50 clock = ~clock;
  end

  // hang guard: twenty-three frames of about 260 cycles fit well inside
  initial
    cycles = 0;
  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (cycles == 12000)
    begin
      err_count = err_count + 1;
      finish_test();
    end
  end

  // expected advertisement right after strap load
  function automatic phyan_word_t adv_exp(input logic [4:0] s);
    adv_exp = {5'h00, s[4], 1'b0, s[3:0], 5'h01};
  endfunction : adv_exp

  task check(input phyan_word_t seen, input phyan_word_t exp);
    compares = compares + 1;
    if (seen !== exp)
    begin
      err_count = err_count + 1;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task rd(input logic [4:0] addr, input phyan_word_t exp);
    mgmt.frame(`PHYAN_OP_READ, addr, PHY, 16'h0000, rdata);
    check(rdata, exp);
  endtask : rd

  task wr(input logic [4:0] addr, input phyan_word_t data);
    mgmt.frame(`PHYAN_OP_WRITE, addr, PHY, data, rdata);
  endtask : wr

  // one-cycle page strobe from the negotiation side
  task page(input logic nxt, input phyan_word_t w);
    @(negedge clock);
    base_page = w;
    next_page = w;
    base_valid = ~nxt;
    next_valid = nxt;
    @(negedge clock);
    base_valid = 1'b0;
    next_valid = 1'b0;
  endtask : page

  // reset held five cycles, then straps must land in the advertisement
  task do_reset(input logic [4:0] s);
    @(negedge clock);
    rst_b = 1'b0;
    straps = s;
    repeat (5) @(negedge clock);
    check(advertise_page, 16'h0001);
    check({15'h0000, mdio_oe}, 16'h0000);
    rst_b = 1'b1;
    repeat (6) @(negedge clock);
    check(advertise_page, adv_exp(s));
    straps = ~s;
    repeat (3) @(negedge clock);
    check(advertise_page, adv_exp(s));
  endtask : do_reset

  task finish_test();
    if (err_count == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : finish_test

  // main sequence
  initial
  begin
    rst_b = 1'b0;
    phy_addr = PHY;
    straps = 5'h00;
    base_valid = 1'b0;
    base_page = 16'h0000;
    next_valid = 1'b0;
    next_page = 16'h0000;
    an_complete = 1'b0;
    err_count = 0;
    compares = 0;
    do_reset(5'h15);
    rd(`PHYAN_OFF_ADVERTISE, adv_exp(5'h15));
    rd(`PHYAN_OFF_IDENT_HIGH, ORG[21:6]);
    rd(`PHYAN_OFF_IDENT_LOW, {ORG[5:0], MODEL, REV});
    wr(`PHYAN_OFF_IDENT_HIGH, 16'h0000);
    wr(`PHYAN_OFF_IDENT_LOW, 16'h0000);
    rd(`PHYAN_OFF_IDENT_HIGH, ORG[21:6]);
    rd(`PHYAN_OFF_IDENT_LOW, {ORG[5:0], MODEL, REV});
    wr(`PHYAN_OFF_ADVERTISE, 16'hFFFF);
    rd(`PHYAN_OFF_ADVERTISE, 16'hA5FF);
    check(advertise_page, 16'hA5FF);
    wr(`PHYAN_OFF_ADVERTISE, 16'h0000);
    rd(`PHYAN_OFF_ADVERTISE, 16'h0000);
    // another address on the pins: the frames are not ours
    phy_addr = PHY ^ 5'h01;
    rd(`PHYAN_OFF_ADVERTISE, 16'hFFFF);
    wr(`PHYAN_OFF_ADVERTISE, 16'h8021);
    phy_addr = PHY;
    // opcodes other than read and write are ignored
    mgmt.frame(2'h3, `PHYAN_OFF_ADVERTISE, PHY, 16'h0000, rdata);
    check(rdata, 16'hFFFF);
    mgmt.frame(2'h0, `PHYAN_OFF_ADVERTISE, PHY, 16'hFFFF, rdata);
    rd(`PHYAN_OFF_ADVERTISE, 16'h0000);
    rd(5'h1F, 16'h0000);
    // partner pages: next page only counts once negotiation finished with bit 15 set
    page(1'b0, 16'h1234);
    rd(`PHYAN_OFF_PARTNER, 16'h1234);
    an_complete = 1'b1;
    page(1'b1, 16'h5678);
    rd(`PHYAN_OFF_PARTNER, 16'h1234);
    wr(`PHYAN_OFF_ADVERTISE, 16'h8001);
    page(1'b1, 16'h5678);
    rd(`PHYAN_OFF_PARTNER, 16'h5678);
    // reset in mid-run with other straps
    an_complete = 1'b0;
    do_reset(5'h0A);
    rd(`PHYAN_OFF_PARTNER, 16'h0000);
    rd(`PHYAN_OFF_ADVERTISE, adv_exp(5'h0A));
    finish_test();
  end
endmodule : testbench
`default_nettype wire
